// file: logic/dcce_pkg.sv
/*
  Shared constants for the channel command/error block: register offsets,
  command and error bit positions, transfer state codes and state encoding.
  Assumes one channel per instance; offsets are byte addresses in the
  channel window.
*/
`default_nettype none
package dcce_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_STS_LO   = 8'h84;
  localparam logic [7:0] OFF_STS_HI   = 8'h88;
  localparam logic [7:0] OFF_CHAIN_LO = 8'h8c;
  localparam logic [7:0] OFF_CHAIN_HI = 8'h90;
  localparam logic [7:0] OFF_CMD      = 8'h94;
  localparam logic [7:0] OFF_CMP_LO   = 8'h98;
  localparam logic [7:0] OFF_CMP_HI   = 8'h9c;
  localparam logic [7:0] OFF_CUR_LO   = 8'ha0;
  localparam logic [7:0] OFF_CUR_HI   = 8'ha4;
  localparam logic [7:0] OFF_ERR      = 8'ha8;
  // command bits
  localparam int CMD_START  = 0;
  localparam int CMD_APPEND = 1;
  localparam int CMD_SUSP   = 2;
  localparam int CMD_ABORT  = 3;
  localparam int CMD_RESUME = 4;
  localparam int CMD_RESET  = 5;
  localparam logic [7:0] CMD_MASK = 8'h3f;
  // error bits
  localparam int ERR_CHAIN = 4;
  localparam int ERR_CMD   = 5;
  localparam int ERR_PAR   = 6;
  localparam int ERR_RD    = 8;
  localparam int ERR_WR    = 9;
  localparam int ERR_CTRL  = 10;
  localparam int ERR_LEN   = 11;
  localparam int ERR_CMP   = 12;
  localparam int ERR_IRQ   = 13;
  localparam logic [15:0] ERR_RW_MASK = 16'h3f70;
  localparam logic [15:0] ERR_RESET   = 16'h0000;
  // alignment of chain and completion addresses, in address bits
  localparam int CHAIN_ALIGN = 6;
  localparam int CMP_ALIGN   = 3;
  // transfer state codes
  localparam logic [2:0] XS_ACTIVE = 3'h0;
  localparam logic [2:0] XS_DONE   = 3'h1;
  localparam logic [2:0] XS_SUSP   = 3'h2;
  localparam logic [2:0] XS_HALT   = 3'h3;
  typedef enum logic [4:0] {
    st_halt = 5'h01,
    st_run  = 5'h02,
    st_susp = 5'h04,
    st_done = 5'h08,
    st_cmpw = 5'h10
  } dcce_state_t;
endpackage : dcce_pkg
`default_nettype wire

// file: logic/dcce_err_if.sv
/*
  Carrier between the channel and its error flag register: set and clear
  vectors in, sticky flags out.
  Assumes both ends share one clock.
*/
`default_nettype none
interface dcce_err_if;
  logic [15:0] set;
  logic [15:0] clr;
  logic [15:0] flags;
  modport ctl  (output set, output clr, input flags);
  modport regs (input set, input clr, output flags);
endinterface : dcce_err_if
`default_nettype wire

// file: logic/dcce_err_regs.sv
/*
  Sticky channel error flags, write-one-to-clear.
  Assumes arst_n is the power-on reset; other resets do not reach here.
*/
`default_nettype none
module dcce_err_regs (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // flag access
  dcce_err_if.regs  e
);
  logic [15:0] flags;
  logic [15:0] next_flags;

  // set wins over a clear in the same cycle; unwritable bits stay zero
  always_comb
  begin
    next_flags = (flags & ~e.clr) | e.set;
    next_flags = next_flags & dcce_pkg::ERR_RW_MASK;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      flags <= dcce_pkg::ERR_RESET;
    else
      flags <= next_flags;
  end

  assign e.flags = flags;

  chk_ro_bits_zero : assert property (@(posedge clk) disable iff (!arst_n)
    (flags & ~dcce_pkg::ERR_RW_MASK) == 16'h0000)
    else $error("read-only error bits not zero");

  chk_set_beats_clear : assert property (@(posedge clk) disable iff (!arst_n)
    ((e.set & dcce_pkg::ERR_RW_MASK) != 16'h0000)
    |=> ((flags & $past(e.set & dcce_pkg::ERR_RW_MASK))
         == $past(e.set & dcce_pkg::ERR_RW_MASK)))
    else $error("error set lost");

  chk_zero_write_keeps : assert property (@(posedge clk) disable iff (!arst_n)
    (e.set == 16'h0000 && e.clr == 16'h0000) |=> $stable(flags))
    else $error("flag changed without set or clear");
endmodule : dcce_err_regs
`default_nettype wire

// file: logic/dcce_channel.sv
/*
  One copy channel: command register, chain and completion addresses,
  current descriptor, status and error tracking, and the sequencing of
  descriptor fetch and completion write.
  Assumes a datapath that fetches and runs a descriptor on desc_req and
  answers with one desc_done pulse carrying its error inputs, and a memory
  writer that accepts cmp_req with one cmp_ack pulse.
*/
// Behaviour
// - reset command halts at once, no status
// - reset keeps descriptor, updates only state field
// - resume refetches current descriptor, follows next
// - abort halts except during completion write, aborting any active transfer
// - suspend stops at boundary, reports suspended
// - append refetches last descriptor, else ignored
// - start fetches first descriptor from chain address
// - several command bits set: command error
// - busy: last command wins, append queued
// - start with errors pending: command error, halted
// - completion write after status fully updated
// - completion address 8-byte aligned
// - bad completion address sets bit 12
// - lower half read latches upper half
// - errors keep channel halted until cleared
// - bits 15, 14, 7 read zero
// - bad interrupt configuration sets bit 13
// - descriptor errors flag, halt, log address
// - parity error also flags direction, halts
// - bad or unaligned chain address sets bit 4
// - state codes active, done, suspended, halted
`default_nettype none
module dcce_channel (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // register access
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  output var  logic [31:0] reg_rdata,
  output var  logic        reg_rvalid,
  // descriptor datapath
  output var  logic        desc_req,
  output var  logic        desc_refetch,
  output var  logic [63:0] desc_addr,
  output var  logic        desc_abort,
  input  wire logic        desc_done,
  input  wire logic        desc_last,
  input  wire logic [63:0] desc_next,
  input  wire logic        err_len,
  input  wire logic        err_ctrl,
  input  wire logic        err_wr,
  input  wire logic        err_rd,
  input  wire logic        err_par,
  input  wire logic        err_par_wr,
  // completion write
  output var  logic        cmp_req,
  output var  logic [63:0] cmp_addr,
  output var  logic [63:0] cmp_data,
  input  wire logic        cmp_ack,
  // interrupt configuration
  input  wire logic        irq_try,
  input  wire logic        msi_enable,
  input  wire logic        msi_callback_enable,
  input  wire logic        legacy_irq_mask,
  // status
  output var  logic [2:0]  xfer_state,
  output var  logic [15:0] err_flags
);
  dcce_pkg::dcce_state_t state, next_state;
  logic [63:0] chain, next_chain;
  logic [63:0] cmp, next_cmp;
  logic        cmp_cfg, next_cmp_cfg;
  logic [7:0]  cmd, next_cmd;
  logic [5:0]  pcmd, next_pcmd;
  logic        pend, next_pend;
  logic        app_pend, next_app_pend;
  logic [63:0] cur, next_cur;
  logic [57:0] sts_addr, next_sts_addr;
  logic [31:0] cur_hi, next_cur_hi;
  logic [31:0] sts_hi, next_sts_hi;
  logic [2:0]  next_xs;
  logic [31:0] next_rdata;
  logic        next_desc_req, next_refetch, next_desc_abort;
  logic [63:0] next_desc_addr, next_cmp_addr, next_cmp_data;
  logic        next_cmp_req;
  logic [15:0] set_v, clr_v;
  logic        wr_cmd, multi, busy, any_err, chain_bad, cmp_bad;
  logic [5:0]  wcmd;

  dcce_err_if eif ();

  dcce_err_regs u_err (
    .clk    (clk),
    .arst_n (arst_n),
    .e      (eif.regs)
  );

  assign eif.set   = set_v;
  assign eif.clr   = clr_v;
  assign err_flags = eif.flags;

  assign wcmd      = reg_wdata[5:0];
  assign wr_cmd    = reg_wr && (reg_addr == dcce_pkg::OFF_CMD);
  assign multi     = (wcmd & (wcmd - 6'h01)) != 6'h00;
  assign busy      = (state == dcce_pkg::st_run) || (state == dcce_pkg::st_cmpw);
  assign any_err   = err_len || err_ctrl || err_wr || err_rd || err_par;
  assign chain_bad = (chain == 64'h0) || (chain[dcce_pkg::CHAIN_ALIGN-1:0] != 6'h00);
  assign cmp_bad   = !cmp_cfg || (cmp == 64'h0);

  always_comb
  begin
    next_state    = state;
    next_chain    = chain;
    next_cmp      = cmp;
    next_cmp_cfg  = cmp_cfg;
    next_cmd      = cmd;
    next_pcmd     = pcmd;
    next_pend     = pend;
    next_app_pend = app_pend;
    next_cur      = cur;
    next_sts_addr = sts_addr;
    next_cur_hi   = cur_hi;
    next_sts_hi   = sts_hi;
    next_xs       = xfer_state;
    next_rdata    = 32'h0000_0000;
    next_desc_req = 1'b0;
    next_refetch  = desc_refetch;
    next_desc_addr  = desc_addr;
    next_desc_abort = 1'b0;
    next_cmp_req  = cmp_req;
    next_cmp_addr = cmp_addr;
    next_cmp_data = cmp_data;
    set_v         = 16'h0000;
    clr_v         = 16'h0000;
    // reads; unmapped offsets answer zero
    if (reg_rd)
    begin
      case (reg_addr)
        dcce_pkg::OFF_STS_LO:
        begin
          next_rdata  = {sts_addr[25:0], 3'h0, xfer_state};
          next_sts_hi = sts_addr[57:26];
        end
        dcce_pkg::OFF_STS_HI:   next_rdata = sts_hi;
        dcce_pkg::OFF_CHAIN_LO: next_rdata = chain[31:0];
        dcce_pkg::OFF_CHAIN_HI: next_rdata = chain[63:32];
        dcce_pkg::OFF_CMD:      next_rdata = {24'h00_0000, cmd};
        dcce_pkg::OFF_CMP_LO:   next_rdata = cmp[31:0];
        dcce_pkg::OFF_CMP_HI:   next_rdata = cmp[63:32];
        dcce_pkg::OFF_CUR_LO:
        begin
          next_rdata  = cur[31:0];
          next_cur_hi = cur[63:32];
        end
        dcce_pkg::OFF_CUR_HI:   next_rdata = cur_hi;
        dcce_pkg::OFF_ERR:      next_rdata = {16'h0000, eif.flags};
        default:                next_rdata = 32'h0000_0000;
      endcase
    end
    // plain register writes
    if (reg_wr)
    begin
      case (reg_addr)
        dcce_pkg::OFF_CHAIN_LO: next_chain[31:0]  = reg_wdata;
        dcce_pkg::OFF_CHAIN_HI: next_chain[63:32] = reg_wdata;
        dcce_pkg::OFF_CMP_LO:
        begin
          next_cmp[31:0] = {reg_wdata[31:dcce_pkg::CMP_ALIGN], 3'h0};
          next_cmp_cfg   = 1'b1;
        end
        dcce_pkg::OFF_CMP_HI:
        begin
          next_cmp[63:32] = reg_wdata;
          next_cmp_cfg    = 1'b1;
        end
        dcce_pkg::OFF_CMD:      next_cmd = reg_wdata[7:0] & dcce_pkg::CMD_MASK;
        dcce_pkg::OFF_ERR:      clr_v = reg_wdata[15:0];
        default:                next_cmd = cmd;
      endcase
    end
    // interrupt attempt with neither mode usable
    if (irq_try && legacy_irq_mask && !(msi_enable && msi_callback_enable))
      set_v[dcce_pkg::ERR_IRQ] = 1'b1;
    case (state)
      dcce_pkg::st_run:
      begin
        if (desc_done)
        begin
          next_sts_addr = cur[63:6];
          next_app_pend = 1'b0;
          if (any_err)
          begin
            set_v[dcce_pkg::ERR_LEN]  = err_len;
            set_v[dcce_pkg::ERR_CTRL] = err_ctrl;
            set_v[dcce_pkg::ERR_PAR]  = err_par;
            set_v[dcce_pkg::ERR_WR]   = err_wr || (err_par && err_par_wr);
            set_v[dcce_pkg::ERR_RD]   = err_rd || (err_par && !err_par_wr);
            next_xs    = dcce_pkg::XS_HALT;
            next_state = dcce_pkg::st_cmpw;
          end
          else if (pend && pcmd[dcce_pkg::CMD_SUSP])
          begin
            next_pend  = 1'b0;
            next_xs    = dcce_pkg::XS_SUSP;
            next_state = dcce_pkg::st_susp;
          end
          else if (desc_last && app_pend)
          begin
            next_desc_req  = 1'b1;
            next_refetch   = 1'b1;
            next_desc_addr = cur;
          end
          else if (desc_last)
          begin
            next_xs    = dcce_pkg::XS_DONE;
            next_state = dcce_pkg::st_cmpw;
          end
          else
          begin
            next_cur       = desc_next;
            next_desc_req  = 1'b1;
            next_refetch   = 1'b0;
            next_desc_addr = desc_next;
          end
        end
      end
      dcce_pkg::st_cmpw:
      begin
        // status already holds its final value when the write goes out
        if (!cmp_req)
        begin
          if (cmp_bad)
          begin
            set_v[dcce_pkg::ERR_CMP] = 1'b1;
            next_xs    = dcce_pkg::XS_HALT;
            next_state = dcce_pkg::st_halt;
          end
          else
          begin
            next_cmp_req  = 1'b1;
            next_cmp_addr = cmp;
            next_cmp_data = {sts_addr, 3'h0, xfer_state};
          end
        end
        else if (cmp_ack)
        begin
          next_cmp_req = 1'b0;
          next_state   = (xfer_state == dcce_pkg::XS_HALT) ?
                         dcce_pkg::st_halt : dcce_pkg::st_done;
        end
      end
      default:
      begin
        if (pend)
        begin
          next_pend = 1'b0;
          if (pcmd[dcce_pkg::CMD_START])
          begin
            if (eif.flags != 16'h0000)
            begin
              set_v[dcce_pkg::ERR_CMD] = 1'b1;
              next_xs    = dcce_pkg::XS_HALT;
              next_state = dcce_pkg::st_halt;
            end
            else if (chain_bad)
            begin
              set_v[dcce_pkg::ERR_CHAIN] = 1'b1;
              next_xs    = dcce_pkg::XS_HALT;
              next_state = dcce_pkg::st_halt;
            end
            else
            begin
              next_cur       = chain;
              next_desc_req  = 1'b1;
              next_refetch   = 1'b0;
              next_desc_addr = chain;
              next_xs        = dcce_pkg::XS_ACTIVE;
              next_state     = dcce_pkg::st_run;
            end
          end
          else if (eif.flags == 16'h0000 &&
                   ((pcmd[dcce_pkg::CMD_APPEND] && state == dcce_pkg::st_done) ||
                    (pcmd[dcce_pkg::CMD_RESUME] && state == dcce_pkg::st_susp)))
          begin
            next_desc_req  = 1'b1;
            next_refetch   = 1'b1;
            next_desc_addr = cur;
            next_xs        = dcce_pkg::XS_ACTIVE;
            next_state     = dcce_pkg::st_run;
          end
        end
      end
    endcase
    // command writes override the sequencer
    if (wr_cmd)
    begin
      if (multi)
      begin
        set_v[dcce_pkg::ERR_CMD] = 1'b1;
        next_pend = 1'b0;
      end
      else if (wcmd[dcce_pkg::CMD_RESET])
      begin
        next_desc_abort = busy;
        next_cmp_req    = 1'b0;
        next_pend       = 1'b0;
        next_app_pend   = 1'b0;
        next_desc_req   = 1'b0;
        next_cur        = cur;
        next_sts_addr   = sts_addr;
        next_xs         = dcce_pkg::XS_HALT;
        next_state      = dcce_pkg::st_halt;
      end
      else if (wcmd[dcce_pkg::CMD_ABORT] && state != dcce_pkg::st_cmpw)
      begin
        next_desc_abort = (state == dcce_pkg::st_run);
        next_desc_req   = 1'b0;
        next_pend       = 1'b0;
        next_app_pend   = 1'b0;
        next_xs         = dcce_pkg::XS_HALT;
        next_state      = dcce_pkg::st_halt;
      end
      else if (wcmd[dcce_pkg::CMD_APPEND] && busy)
        next_app_pend = 1'b1;
      else
      begin
        // a later command replaces one not yet serviced
        next_pcmd = wcmd;
        next_pend = wcmd != 6'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state        <= dcce_pkg::st_halt;
      chain        <= 64'h0;
      cmp          <= 64'h0;
      cmp_cfg      <= 1'b0;
      cmd          <= 8'h00;
      pcmd         <= 6'h00;
      pend         <= 1'b0;
      app_pend     <= 1'b0;
      cur          <= 64'h0;
      sts_addr     <= 58'h0;
      cur_hi       <= 32'h0000_0000;
      sts_hi       <= 32'h0000_0000;
      xfer_state   <= dcce_pkg::XS_HALT;
      reg_rdata    <= 32'h0000_0000;
      reg_rvalid   <= 1'b0;
      desc_req     <= 1'b0;
      desc_refetch <= 1'b0;
      desc_addr    <= 64'h0;
      desc_abort   <= 1'b0;
      cmp_req      <= 1'b0;
      cmp_addr     <= 64'h0;
      cmp_data     <= 64'h0;
    end
    else
    begin
      state        <= next_state;
      chain        <= next_chain;
      cmp          <= next_cmp;
      cmp_cfg      <= next_cmp_cfg;
      cmd          <= next_cmd;
      pcmd         <= next_pcmd;
      pend         <= next_pend;
      app_pend     <= next_app_pend;
      cur          <= next_cur;
      sts_addr     <= next_sts_addr;
      cur_hi       <= next_cur_hi;
      sts_hi       <= next_sts_hi;
      xfer_state   <= next_xs;
      reg_rdata    <= next_rdata;
      reg_rvalid   <= reg_rd;
      desc_req     <= next_desc_req;
      desc_refetch <= next_refetch;
      desc_addr    <= next_desc_addr;
      desc_abort   <= next_desc_abort;
      cmp_req      <= next_cmp_req;
      cmp_addr     <= next_cmp_addr;
      cmp_data     <= next_cmp_data;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_fatal;
    state == dcce_pkg::st_run && desc_done && any_err;
  endsequence

  chk_multi_cmd_err : assert property (wr_cmd && multi |=> err_flags[5])
    else $error("multi-bit command did not flag");
  chk_reset_halts : assert property (
    wr_cmd && !multi && wcmd[5] |=> state == dcce_pkg::st_halt
      && xfer_state == dcce_pkg::XS_HALT && !cmp_req ##1 !cmp_req)
    else $error("reset command did not halt quietly");
  chk_halt_sticky : assert property (
    state == dcce_pkg::st_halt && err_flags != 16'h0000 |=> state == dcce_pkg::st_halt)
    else $error("left halt with errors pending");
  chk_chain_align : assert property (
    desc_req && !desc_refetch && $past(state) != dcce_pkg::st_run |->
      desc_addr[5:0] == 6'h00 && desc_addr != 64'h0)
    else $error("bad chain address fetched");
  chk_cmp_write : assert property (cmp_req |->
    cmp_addr[2:0] == 3'h0 && cmp_data[2:0] == xfer_state && state == dcce_pkg::st_cmpw)
    else $error("completion write inconsistent");
  chk_cur_split : assert property (
    reg_rd && reg_addr == dcce_pkg::OFF_CUR_LO |=> cur_hi == $past(cur[63:32]))
    else $error("upper descriptor half not latched");
  chk_irq_cfg : assert property (
    irq_try && legacy_irq_mask && !(msi_enable && msi_callback_enable) |=> err_flags[13])
    else $error("interrupt config error missed");
  chk_par_dir : assert property (
    s_fatal and (err_par && err_par_wr) |=> err_flags[6] && err_flags[9])
    else $error("write parity error not flagged");
  chk_fatal_path : assert property (
    s_fatal |=> state == dcce_pkg::st_cmpw && xfer_state == dcce_pkg::XS_HALT
      && sts_addr == $past(cur[63:6]))
    else $error("descriptor error not logged");
  chk_susp_code : assert property (
    state == dcce_pkg::st_susp |-> xfer_state == dcce_pkg::XS_SUSP && !desc_req)
    else $error("suspended state code wrong");
endmodule : dcce_channel
`default_nettype wire

// file: testbench/dcce_far.sv
/*
  Far-side model: descriptor datapath and completion memory writer.
  Assumes one clock shared with the channel; the bench sets lat, left, pick.
*/
`default_nettype none
module dcce_far (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // descriptor link
  input  wire logic        desc_req,
  input  wire logic        desc_refetch,
  input  wire logic [63:0] desc_addr,
  input  wire logic        desc_abort,
  output var  logic        desc_done,
  output var  logic        desc_last,
  output var  logic [63:0] desc_next,
  output var  logic [5:0]  errs,
  // completion write
  input  wire logic        cmp_req,
  input  wire logic [63:0] cmp_addr,
  input  wire logic [63:0] cmp_data,
  output var  logic        cmp_ack
);
  int          lat = 2;
  int          left = 1;
  int          nreq, nab, ncmp, dc, ac;
  logic [5:0]  pick = '0;
  logic [63:0] ra, cd, ca;
  logic        rf, busy;
  // unqualified lines show the inverse, so a stale sample never looks right
  assign desc_last = desc_done ? left == 0 : left != 0;
  assign desc_next = desc_done ? ra + 64'h40 : ~(ra + 64'h40);
  assign errs      = desc_done ? pick : ~pick;
  always @(posedge clk or negedge arst_n)
    if (!arst_n)
    begin
      {desc_done, cmp_ack, busy} <= '0;
      ac <= 0;
    end
    else
    begin
      desc_done <= 1'b0;
      dc        <= dc + 1;
      if (desc_req)
      begin
        busy <= 1'b1;
        dc   <= 0;
        ra   <= desc_addr;
        rf   <= desc_refetch;
        nreq <= nreq + 1;
      end
      else if (desc_abort)
      begin
        busy <= 1'b0;
        nab  <= nab + 1;
      end
      else if (busy && dc >= lat)
      begin
        busy      <= 1'b0;
        desc_done <= 1'b1;
        left      <= left - 1;
      end
      // one write at a time: ack only after the request stood lat+1 cycles
      cmp_ack <= cmp_req && !cmp_ack && ac == lat;
      ac      <= (cmp_req && !cmp_ack) ? ac + 1 : 0;
      if (cmp_ack)
      begin
        ncmp <= ncmp + 1;
        cd   <= cmp_data;
        ca   <= cmp_addr;
      end
    end
endmodule : dcce_far
`default_nettype wire

// file: testbench/tb_dma_channel_command_error.sv
/*
  Self-checking bench: register tasks drive commands, far model answers.
  Assumes the design package, the channel and the far-side model.
*/
`default_nettype none
module tb_dma_channel_command_error;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [63:0] ch = 64'h0000_0005_0000_2000;
  localparam logic [63:0] ca = 64'h0000_0003_0000_1008;
  logic        clk, arst_n, reg_wr, reg_rd, reg_rvalid, irq_try;
  logic        msi_enable, msi_callback_enable, legacy_irq_mask;
  logic        desc_req, desc_refetch, desc_abort, desc_done, desc_last, cmp_req, cmp_ack;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [63:0] desc_addr, desc_next, cmp_addr, cmp_data;
  logic [5:0]  errs;
  logic [2:0]  xfer_state;
  logic [15:0] err_flags;
  logic [5:0]  p[6] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h30};
  logic [15:0] f[6] = '{16'h0800, 16'h0400, 16'h0200, 16'h0100, 16'h0140, 16'h0240};
  int          err_total, n_checks;
  dcce_channel i_dcce_channel (
    .clk, .arst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .desc_req, .desc_refetch, .desc_addr, .desc_abort, .desc_done, .desc_last, .desc_next,
    .err_len(errs[0]), .err_ctrl(errs[1]), .err_wr(errs[2]), .err_rd(errs[3]),
    .err_par(errs[4]), .err_par_wr(errs[5]), .cmp_req, .cmp_addr, .cmp_data, .cmp_ack,
    .irq_try, .msi_enable, .msi_callback_enable, .legacy_irq_mask, .xfer_state, .err_flags
  );
  dcce_far i_dcce_far (
    .clk, .arst_n, .desc_req, .desc_refetch, .desc_addr, .desc_abort, .desc_done,
    .desc_last, .desc_next, .errs, .cmp_req, .cmp_addr, .cmp_data, .cmp_ack
  );
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    n_checks++;
    if (s !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // all drives land 1 ns after the edge, clear of the design's sampling
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    tick();
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    tick();
    reg_wr = 1'b0;
  endtask : wr
  task automatic wr64(input logic [7:0] a, input logic [63:0] d);
    wr(a, d[31:0]);
    wr(a + 8'h4, d[63:32]);
  endtask : wr64
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    tick();
    reg_rd   = 1'b1;
    reg_addr = a;
    tick();
    reg_rd = 1'b0;
    for (int k = 0; k < 4 && reg_rvalid !== 1'b1; k++) tick();
    chk(n, reg_rdata, e);
  endtask : rd
  task automatic wst(input logic [2:0] s);
    for (int k = 0; k < 300 && xfer_state !== s; k++) tick();
    chk("xfer_state", xfer_state, s);
  endtask : wst
  task automatic wcmp(input int n);
    for (int k = 0; k < 300 && i_dcce_far.ncmp != n; k++) tick();
    chk("completions", i_dcce_far.ncmp, n);
  endtask : wcmp
  initial
  begin
    #100us;
    err_total++;
    summarize();
  end
  initial
  begin
    {arst_n, reg_wr, reg_rd, irq_try, msi_enable, msi_callback_enable} = '0;
    legacy_irq_mask = 1'b0;
    reg_addr        = '0;
    reg_wdata       = '0;
    repeat (2) @(posedge clk);
    #1 arst_n = 1'b1;
    chk("reset state", xfer_state, dcce_pkg::XS_HALT);
    rd(dcce_pkg::OFF_ERR, 32'h0, "err reset");
    wr64(dcce_pkg::OFF_CHAIN_LO, ch);
    wr(dcce_pkg::OFF_CMD, 32'h01);
    wst(dcce_pkg::XS_ACTIVE);
    chk("first desc", desc_addr, ch);
    wst(dcce_pkg::XS_HALT);
    chk("cmp addr err", err_flags, 16'h1000);
    chk("no completion", i_dcce_far.ncmp, 0);
    wr(dcce_pkg::OFF_ERR, 32'h0);
    chk("w0 keeps", err_flags, 16'h1000);
    wr(dcce_pkg::OFF_ERR, 32'hffff);
    wr64(dcce_pkg::OFF_CMP_LO, ca);
    i_dcce_far.left = 2;
    wr(dcce_pkg::OFF_CMD, 32'h01);
    wcmp(1);
    chk("done state", xfer_state, dcce_pkg::XS_DONE);
    chk("status", i_dcce_far.cd, (ch + 64'h40) | 64'h1);
    chk("cmp target", i_dcce_far.ca, ca);
    rd(dcce_pkg::OFF_CUR_LO, ch[31:0] + 32'h40, "cur lo");
    rd(dcce_pkg::OFF_CUR_HI, ch[63:32], "cur hi");
    rd(dcce_pkg::OFF_STS_LO, ch[31:0] + 32'h41, "sts lo");
    rd(dcce_pkg::OFF_STS_HI, ch[63:32], "sts hi");
    i_dcce_far.left = 1;
    wr(dcce_pkg::OFF_CMD, 32'h02);
    wcmp(2);
    chk("append addr", i_dcce_far.ra, ch + 64'h40);
    chk("append refetch", i_dcce_far.rf, 1'b1);
    // append while the first of two descriptors is not at the end: dropped
    i_dcce_far.left = 2;
    i_dcce_far.lat  = 20;
    wr(dcce_pkg::OFF_CMD, 32'h01);
    wst(dcce_pkg::XS_ACTIVE);
    wr(dcce_pkg::OFF_CMD, 32'h02);
    wcmp(3);
    chk("append dropped", i_dcce_far.nreq, 6);
    i_dcce_far.left = 3;
    wr(dcce_pkg::OFF_CMD, 32'h01);
    wst(dcce_pkg::XS_ACTIVE);
    wr(dcce_pkg::OFF_CMD, 32'h04);
    wst(dcce_pkg::XS_SUSP);
    chk("susp boundary", i_dcce_far.nreq, 7);
    wr(dcce_pkg::OFF_CMD, 32'h10);
    wst(dcce_pkg::XS_ACTIVE);
    chk("resume addr", desc_addr, ch);
    chk("resume refetch", desc_refetch, 1'b1);
    wr(dcce_pkg::OFF_CMD, 32'h08);
    wst(dcce_pkg::XS_HALT);
    tick();
    chk("abort", i_dcce_far.nab, 1);
    wr(dcce_pkg::OFF_CMD, 32'h01);
    wst(dcce_pkg::XS_ACTIVE);
    wr(dcce_pkg::OFF_CMD, 32'h20);
    wst(dcce_pkg::XS_HALT);
    tick();
    chk("reset abort", i_dcce_far.nab, 2);
    rd(dcce_pkg::OFF_CUR_LO, ch[31:0], "cur kept");
    chk("reset no status", i_dcce_far.ncmp, 3);
    wr(dcce_pkg::OFF_CMD, 32'h03);
    tick();
    chk("multi bit", err_flags, 16'h0020);
    wr(dcce_pkg::OFF_CMD, 32'h01);
    repeat (3) tick();
    chk("start blocked", i_dcce_far.nreq, 9);
    chk("held halted", xfer_state, dcce_pkg::XS_HALT);
    rd(dcce_pkg::OFF_ERR, 32'h20, "err read");
    wr(dcce_pkg::OFF_CMD, 32'h0);
    wr(dcce_pkg::OFF_ERR, 32'hffff);
    tick();
    chk("cleared", err_flags, 16'h0);
    wr64(dcce_pkg::OFF_CHAIN_LO, ch | 64'h10);
    wr(dcce_pkg::OFF_CMD, 32'h01);
    repeat (3) tick();
    chk("chain align", err_flags, 16'h0010);
    chk("no fetch", i_dcce_far.nreq, 9);
    wr64(dcce_pkg::OFF_CHAIN_LO, ch);
    wr(dcce_pkg::OFF_ERR, 32'hffff);
    i_dcce_far.lat = 2;
    for (int k = 0; k < 6; k++)
    begin
      i_dcce_far.pick = p[k];
      i_dcce_far.left = 1;
      wr(dcce_pkg::OFF_CMD, 32'h01);
      wst(dcce_pkg::XS_ACTIVE);
      wcmp(4 + k);
      chk("desc err", err_flags, f[k]);
      chk("err halt", xfer_state, dcce_pkg::XS_HALT);
      chk("err status", i_dcce_far.cd, ch | 64'h3);
      i_dcce_far.pick = '0;
      wr(dcce_pkg::OFF_ERR, 32'hffff);
    end
    for (int k = 0; k < 5; k++)
    begin
      legacy_irq_mask     = k < 4;
      msi_enable          = k[1];
      msi_callback_enable = k[0];
      tick();
      irq_try = 1'b1;
      tick();
      irq_try = 1'b0;
      tick();
      chk("int cfg", err_flags[13], k < 3);
      wr(dcce_pkg::OFF_ERR, 32'hffff);
    end
    summarize();
  end
endmodule : tb_dma_channel_command_error
`default_nettype wire
